/* rtl/ipcr_pkg.sv */
// Purpose: Constants and types for the port block.
// Assumes: Avalon-MM register slave with 32-bit data.
// Notes:   Register offsets are byte addresses; data sits in the low byte.
package ipcr_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam int AW = 5;
	localparam logic [AW-1:0] A_CTL1 = 5'h00; // Primary control
	localparam logic [AW-1:0] A_CTL2 = 5'h04; // Secondary control
	localparam logic [AW-1:0] A_BUF = 5'h08; // Shift buffer
	localparam logic [AW-1:0] A_BAUD = 5'h0C; // Baud or slave address value
	localparam logic [AW-1:0] A_IST = 5'h10; // Sticky event status
	localparam logic [AW-1:0] A_IMSK = 5'h14; // Event mask
	localparam logic [AW-1:0] A_BUS = 5'h18; // Engine state, read only

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int C1_WRITE_COLLISION_FLAG = 7; // Write collision flag
	localparam int C1_OV = 6; // Receive overflow flag
	localparam int C1_EN = 5; // Port enable bit
	localparam int C1_CKP = 4; // Clock release bit
	localparam int C2_SEN = 0; // Start request or slave stretch enable
	localparam int C2_RESTART_REQUEST_BIT = 1; // Restart request
	localparam int C2_PEN = 2; // Stop request
	localparam int C2_MASTER_RECEIVE_REQUEST = 3; // Master receive request
	localparam int C2_ACK_SEQUENCE_REQUEST = 4; // Ack sequence request
	localparam int C2_ACKDT = 5; // Ack level sent in ack sequence
	localparam int C2_ACKST = 6; // Ack level seen after master transmit
	localparam int C2_GCEN = 7; // Stored only
	localparam int I_BYTE = 0; // Byte or condition finished
	localparam int I_START = 1; // Start seen (slave, start/stop modes)
	localparam int I_STOP = 2; // Stop seen (slave, start/stop modes)
	localparam int I_COL = 3; // Write collision
	localparam int I_OV = 4; // Receive overflow
	localparam int NIRQ = 5;

	// ---------------------------------------------------------------
	// Reset values, mode codes, counts
	// ---------------------------------------------------------------
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic [3:0] MODE_SLV10_SS = 4'hF;
	localparam logic [3:0] MODE_SLV7_SS = 4'hE;
	localparam logic [3:0] MODE_FWM = 4'hB;
	localparam logic [3:0] MODE_MST = 4'h8;
	localparam logic [3:0] MODE_SLV10 = 4'h7;
	localparam logic [3:0] MODE_SLV7 = 4'h6;
	localparam logic [1:0] PH_LAST = 2'h3; // Four quarter ticks per bus bit
	localparam logic [3:0] BIT_LAST = 4'h7; // Last data bit index
	localparam logic [3:0] BIT_ACK = 4'h8; // Ninth clock index

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [AW-1:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} ipcr_avs_req_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} ipcr_pin_in_t;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} ipcr_pin_out_t;

	typedef enum logic [6:0] {
		M_IDLE = 7'h01,
		M_START = 7'h02,
		M_RSTART = 7'h04,
		M_STOP = 7'h08,
		M_TX = 7'h10,
		M_RX = 7'h20,
		M_ACK = 7'h40
	} ipcr_mst_t;

endpackage

/* rtl/ipcr_port.sv */
// Purpose: Two-wire port: registers, master engine and slave.
// Assumes: Synchronous pin inputs; pull-ups on both lines.
// Notes:   Master does not follow clock stretching by other devices.
//
// Local design decisions: the register addresses and the Avalon-MM register port.

// Contract
// RULE1: master buffer write while busy sets collision
// RULE2: slave buffer write while shifting sets collision
// RULE3: byte arriving into full buffer sets overflow; a slave address byte into a full buffer is nacked without setting it
// RULE4: enable bit hands pins to port
// RULE5: clear enable returns pins to GPIO
// RULE6: software keeps both pins as inputs
// RULE7: slave holds clock low while release bit zero
// RULE8: codes 1111/1110 slave with start/stop events
// RULE9: codes 0111/0110 slave without start/stop events
// RULE10: code 1000 master, clock Fosc/(4*(value+1))
// RULE11: code 1011 firmware master, slave idle
// RULE12: other codes select no two-wire operation
// RULE13: receive request clocks in one byte
// RULE14: stop request drives stop, self-clears
// RULE15: start request drives start, self-clears
// RULE16: zero start bit leaves start logic idle
// RULE17: one master request at a time, idle only
// RULE18: both control registers reset to zero
module ipcr_port (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Avalon-MM slave
	input wire ipcr_pkg::ipcr_avs_req_t avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Interrupt
	output logic irq,
	// Two-wire pins and the general-purpose drive they fall back to
	input wire ipcr_pkg::ipcr_pin_in_t pins_in,
	input wire ipcr_pkg::ipcr_pin_out_t gpio_out,
	output ipcr_pkg::ipcr_pin_out_t pins_out,
	output logic port_active
);
	import ipcr_pkg::*;

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [7:0] ctl1_r; // Primary control
	logic [7:0] ctl2_r; // Secondary control
	logic [7:0] buf_r; // Shift buffer
	logic buf_full_r; // Buffer holds an unread byte
	logic [7:0] baud_r; // Baud or slave address value
	logic [7:0] sr_r; // Shift register
	logic [NIRQ-1:0] ist_r; // Sticky events
	logic [NIRQ-1:0] imsk_r; // Event mask
	logic ack_r; // Bus access in its answer cycle
	logic [31:0] rdata_r; // Read data
	logic wr_en; // Accepted write, low byte lane
	logic rd_buf; // Accepted read of the buffer
	logic [3:0] mode; // Port mode field
	logic is_master; // Hardware master selected
	logic is_slave; // One of the four slave modes
	logic ss_irq; // Start/stop events enabled
	ipcr_mst_t m_st; // Master engine state
	logic [1:0] ph_r; // Quarter phase within a bus bit
	logic [3:0] bit_r; // Bit index within a byte
	logic [7:0] brg_r; // Quarter-tick divider
	logic tick; // One quarter bit period elapsed
	logic m_end; // Last quarter of a master bit
	logic m_done; // Master operation finished
	logic m_scl_r; // Master clock drive, 1 = released
	logic m_sda_r; // Master data drive, 1 = released
	logic ack_stat_r; // Ack level from slave after transmit
	logic buf_wr; // Accepted write of the buffer
	logic tx_go; // Buffer write starts master transmit
	logic m_col; // Master collision
	logic s_scl_q; // Previous clock level
	logic s_sda_q; // Previous data level
	logic s_start; // Start condition seen
	logic s_stop; // Stop condition seen
	logic s_rise; // Clock rising edge
	logic s_fall; // Clock falling edge
	logic s_act_r; // Slave inside an addressed transfer
	logic s_adr_r; // Next byte is the address
	logic s_tx_r; // Slave is transmitting
	logic s_load_r; // Transmit byte loaded, not yet sent
	logic [3:0] s_cnt_r; // Slave bit counter
	logic s_sda_r; // Slave data drive, 1 = released
	logic s_col; // Slave collision
	logic s_byte; // Slave finished a byte
	logic s_match; // Address matches
	logic s_ovf; // Slave data byte into full buffer
	logic s_ld; // Slave loads buffer
	logic s_ckp_clr; // Slave auto-stretch
	logic m_ld; // Master receive loads buffer
	logic m_ovf; // Master receive into full buffer
	logic [NIRQ-1:0] ev; // Event pulses

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	assign mode = ctl1_r[3:0];
	assign is_master = ctl1_r[C1_EN] && (mode == MODE_MST); // RULE10
	// Firmware master code leaves both engines idle. // RULE11
	assign is_slave = ctl1_r[C1_EN] && (mode == MODE_SLV10_SS || mode == MODE_SLV7_SS ||
		mode == MODE_SLV10 || mode == MODE_SLV7); // RULE8 RULE9 RULE12
	assign ss_irq = mode == MODE_SLV10_SS || mode == MODE_SLV7_SS; // RULE8
	assign port_active = ctl1_r[C1_EN];

	// ---------------------------------------------------------------
	// Avalon-MM slave: one wait cycle on every access
	// ---------------------------------------------------------------
	assign avs_waitrequest = (avs_req.read || avs_req.write) && !ack_r;
	assign wr_en = avs_req.write && ack_r && avs_req.byteenable[0];
	assign rd_buf = avs_req.read && ack_r && avs_req.address == A_BUF;
	assign buf_wr = wr_en && avs_req.address == A_BUF;
	assign avs_readdata = rdata_r;

	// Answer phase toggles so back-to-back requests each get a wait
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			ack_r <= 1'b0;
		else
			ack_r <= (avs_req.read || avs_req.write) && !ack_r;
	end

	// Read data captured in the wait cycle, so it stands at the answer edge
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rdata_r <= 32'h0000_0000;
		end else if (avs_req.read && !ack_r) begin
			case (avs_req.address)
				A_CTL1: rdata_r <= {24'h00_0000, ctl1_r};
				A_CTL2: rdata_r <= {24'h00_0000, ctl2_r[7], ack_stat_r, ctl2_r[5:0]};
				A_BUF: rdata_r <= {24'h00_0000, buf_r};
				A_BAUD: rdata_r <= {24'h00_0000, baud_r};
				A_IST: rdata_r <= {27'h000_0000, ist_r};
				A_IMSK: rdata_r <= {27'h000_0000, imsk_r};
				A_BUS: rdata_r <= {27'h000_0000, s_tx_r, s_act_r, m_st != M_IDLE,
					ack_stat_r, buf_full_r};
				// Unmapped offsets read as zero
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Primary control: hardware set wins over clear
	// ---------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ctl1_r <= CTL_RST; // RULE18
		end else begin
			if (wr_en && avs_req.address == A_CTL1)
				ctl1_r <= avs_req.writedata[7:0];
			if (m_col || s_col)
				ctl1_r[C1_WRITE_COLLISION_FLAG] <= 1'b1; // RULE1 RULE2
			if (m_ovf || s_ovf)
				ctl1_r[C1_OV] <= 1'b1; // RULE3
			// Hardware stretch
			if (s_ckp_clr)
				ctl1_r[C1_CKP] <= 1'b0; // RULE7
		end
	end

	// ---------------------------------------------------------------
	// Secondary control: master requests self-clear
	// ---------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ctl2_r <= CTL_RST; // RULE18
		end else begin
			if (wr_en && avs_req.address == A_CTL2)
				ctl2_r <= avs_req.writedata[7:0];
			if (m_done) begin
				case (m_st)
					M_START: ctl2_r[C2_SEN] <= 1'b0; // RULE15
					M_RSTART: ctl2_r[C2_RESTART_REQUEST_BIT] <= 1'b0;
					M_STOP: ctl2_r[C2_PEN] <= 1'b0; // RULE14
					M_RX: ctl2_r[C2_MASTER_RECEIVE_REQUEST] <= 1'b0; // RULE13
					M_ACK: ctl2_r[C2_ACK_SEQUENCE_REQUEST] <= 1'b0;
					default: ;
				endcase
			end
		end
	end

	// Baud or address value and event mask
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			baud_r <= BAUD_RST;
			imsk_r <= '0;
		end else if (wr_en) begin
			if (avs_req.address == A_BAUD)
				baud_r <= avs_req.writedata[7:0];
			if (avs_req.address == A_IMSK)
				imsk_r <= avs_req.writedata[NIRQ-1:0];
		end
	end

	// ---------------------------------------------------------------
	// Interrupts: sticky, write one to clear, set wins
	// ---------------------------------------------------------------
	assign ev[I_BYTE] = m_done || s_byte;
	assign ev[I_START] = s_start && ss_irq;
	assign ev[I_STOP] = s_stop && ss_irq;
	assign ev[I_COL] = m_col || s_col;
	assign ev[I_OV] = m_ovf || s_ovf;

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			ist_r <= '0;
		else if (wr_en && avs_req.address == A_IST)
			ist_r <= (ist_r & ~avs_req.writedata[NIRQ-1:0]) | ev;
		else
			ist_r <= ist_r | ev;
	end

	assign irq = |(ist_r & imsk_r);

	// ---------------------------------------------------------------
	// Shift buffer: loaded by software or a received byte
	// ---------------------------------------------------------------
	assign tx_go = buf_wr && is_master && m_st == M_IDLE;
	assign m_col = buf_wr && is_master && m_st != M_IDLE; // RULE1
	assign s_col = buf_wr && is_slave && s_tx_r && s_load_r; // RULE2

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			buf_r <= 8'h00;
			buf_full_r <= 1'b0;
		end else begin
			// A colliding write is dropped so the byte in flight survives
			if (buf_wr && !m_col && !s_col)
				buf_r <= avs_req.writedata[7:0];
			if (s_ld || m_ld) begin
				buf_r <= sr_r;
				buf_full_r <= 1'b1;
			end else if (rd_buf || !ctl1_r[C1_EN]) begin
				buf_full_r <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Master engine: four quarter ticks per bit
	// ---------------------------------------------------------------
	assign tick = brg_r == 8'h00;
	assign m_end = tick && ph_r == PH_LAST;
	assign m_ld = m_st == M_RX && m_end && bit_r == BIT_LAST && !buf_full_r;
	assign m_ovf = m_st == M_RX && m_end && bit_r == BIT_LAST && buf_full_r; // RULE3

	always_comb begin
		case (m_st)
			M_START, M_RSTART, M_STOP, M_ACK: m_done = m_end;
			M_TX: m_done = m_end && bit_r == BIT_ACK;
			M_RX: m_done = m_end && bit_r == BIT_LAST;
			default: m_done = 1'b0;
		endcase
	end

	// Quarter tick divider: bus clock is clock / (4 * (value + 1))
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			brg_r <= BAUD_RST;
		else if (m_st == M_IDLE || tick)
			brg_r <= baud_r; // RULE10
		else
			brg_r <= brg_r - 8'h01;
	end

	// State, phase and bit counters
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			m_st <= M_IDLE;
			ph_r <= 2'h0;
			bit_r <= 4'h0;
		end else if (!is_master) begin
			m_st <= M_IDLE;
		end else if (m_st == M_IDLE) begin
			ph_r <= 2'h0;
			bit_r <= 4'h0;
			// Fixed priority; a zero start bit starts nothing // RULE16 RULE17
			if (ctl2_r[C2_SEN])
				m_st <= M_START; // RULE15
			else if (ctl2_r[C2_RESTART_REQUEST_BIT])
				m_st <= M_RSTART;
			else if (ctl2_r[C2_PEN])
				m_st <= M_STOP; // RULE14
			else if (ctl2_r[C2_MASTER_RECEIVE_REQUEST])
				m_st <= M_RX; // RULE13
			else if (ctl2_r[C2_ACK_SEQUENCE_REQUEST])
				m_st <= M_ACK;
			else if (tx_go)
				m_st <= M_TX;
		end else if (tick) begin
			ph_r <= ph_r + 2'h1;
			if (ph_r == PH_LAST)
				bit_r <= bit_r + 4'h1;
			if (m_done)
				m_st <= M_IDLE;
		end
	end

	// Line drive per phase; held between operations
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			m_scl_r <= 1'b1;
			m_sda_r <= 1'b1;
		end else if (!is_master) begin
			m_scl_r <= 1'b1;
			m_sda_r <= 1'b1;
		end else begin
			case (m_st)
				M_START: begin
					m_scl_r <= ph_r != PH_LAST; // RULE15
					m_sda_r <= !ph_r[1];
				end
				M_RSTART: begin
					m_scl_r <= ph_r[0] ^ ph_r[1];
					m_sda_r <= !ph_r[1];
				end
				M_STOP: begin
					m_scl_r <= ph_r != 2'h0; // RULE14
					m_sda_r <= ph_r[1];
				end
				M_TX: begin
					m_scl_r <= ph_r[0] ^ ph_r[1];
					m_sda_r <= bit_r == BIT_ACK ? 1'b1 : sr_r[7];
				end
				M_RX: begin
					m_scl_r <= ph_r[0] ^ ph_r[1]; // RULE13
					m_sda_r <= 1'b1;
				end
				M_ACK: begin
					m_scl_r <= ph_r[0] ^ ph_r[1];
					m_sda_r <= ctl2_r[C2_ACKDT];
				end
				default: ;
			endcase
		end
	end

	// Ack seen on the ninth clock of a transmit
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			ack_stat_r <= 1'b0;
		else if (m_st == M_TX && tick && ph_r == 2'h2 && bit_r == BIT_ACK)
			ack_stat_r <= pins_in.sda;
	end

	// ---------------------------------------------------------------
	// Slave: edge and condition detection
	// ---------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_scl_q <= 1'b1;
			s_sda_q <= 1'b1;
		end else begin
			s_scl_q <= pins_in.scl;
			s_sda_q <= pins_in.sda;
		end
	end

	assign s_start = is_slave && pins_in.scl && s_scl_q && s_sda_q && !pins_in.sda;
	assign s_stop = is_slave && pins_in.scl && s_scl_q && !s_sda_q && pins_in.sda;
	assign s_rise = is_slave && s_act_r && pins_in.scl && !s_scl_q;
	assign s_fall = is_slave && s_act_r && !pins_in.scl && s_scl_q;
	assign s_match = sr_r[7:1] == baud_r[7:1];
	assign s_byte = s_fall && s_cnt_r == BIT_LAST && !s_tx_r && (!s_adr_r || s_match);
	assign s_ld = s_byte && !buf_full_r && !ctl1_r[C1_OV];
	assign s_ovf = s_byte && !s_adr_r && buf_full_r; // RULE3
	// Auto stretch: after a read address, after each sent byte the master acks, and on a
	// buffered receive when stretching is enabled
	assign s_ckp_clr = s_fall && s_cnt_r == BIT_ACK &&
		(s_tx_r || (ctl2_r[C2_SEN] && buf_full_r)); // RULE7

	// Transfer tracking
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_act_r <= 1'b0;
			s_adr_r <= 1'b0;
			s_tx_r <= 1'b0;
			s_cnt_r <= 4'h0;
		end else if (!is_slave || s_stop) begin
			s_act_r <= 1'b0;
			s_tx_r <= 1'b0;
		end else if (s_start) begin
			s_act_r <= 1'b1;
			s_adr_r <= 1'b1;
			s_tx_r <= 1'b0;
			s_cnt_r <= 4'h0;
		end else if (s_rise && s_cnt_r == BIT_ACK && s_tx_r && pins_in.sda) begin
			// Master nack: transfer over
			s_act_r <= 1'b0;
			s_tx_r <= 1'b0;
		end else if (s_fall) begin
			if (s_cnt_r == BIT_LAST) begin
				s_cnt_r <= BIT_ACK;
				if (s_adr_r && !s_match)
					s_act_r <= 1'b0;
				if (s_adr_r && s_match)
					s_tx_r <= sr_r[0];
			end else if (s_cnt_r == BIT_ACK) begin
				s_cnt_r <= 4'h0;
				s_adr_r <= 1'b0;
			end else begin
				s_cnt_r <= s_cnt_r + 4'h1;
			end
		end
	end

	// Slave data drive: ack, or transmit bits on clock falls
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_sda_r <= 1'b1;
		end else if (!is_slave || !s_act_r || s_start || s_stop) begin
			s_sda_r <= 1'b1;
		end else if (s_fall) begin
			if (s_cnt_r == BIT_LAST)
				s_sda_r <= s_tx_r && !s_adr_r ? 1'b1 : !s_ld;
			else if (s_cnt_r == BIT_ACK)
				s_sda_r <= s_tx_r || (s_adr_r && sr_r[0]) ? sr_r[7] : 1'b1;
			else if (s_tx_r)
				s_sda_r <= sr_r[6];
		end else if (buf_wr && s_tx_r && !s_col && s_cnt_r == BIT_ACK) begin
			s_sda_r <= 1'b1;
		end
	end

	// Transmit byte loaded, not yet sent
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			s_load_r <= 1'b0;
		else if (!is_slave || !s_tx_r)
			s_load_r <= 1'b0;
		else if (buf_wr)
			s_load_r <= 1'b1;
		else if (s_fall && s_cnt_r == BIT_LAST)
			s_load_r <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Shift register shared by master and slave
	// ---------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sr_r <= 8'h00;
		end else if (buf_wr && !m_col && !s_col) begin
			// A buffer write also loads the shift register
			sr_r <= avs_req.writedata[7:0];
		end else if (m_st == M_RX && tick && ph_r == 2'h2) begin
			sr_r <= {sr_r[6:0], pins_in.sda};
		end else if (m_st == M_TX && m_end && bit_r != BIT_ACK) begin
			sr_r <= {sr_r[6:0], 1'b0};
		end else if (s_rise && !s_tx_r && s_cnt_r != BIT_ACK) begin
			sr_r <= {sr_r[6:0], pins_in.sda};
		end else if (s_fall && s_tx_r && s_cnt_r != BIT_ACK && s_cnt_r != BIT_LAST) begin
			sr_r <= {sr_r[6:0], 1'b0};
		end
	end

	// ---------------------------------------------------------------
	// Pin ownership: port when enabled, else GPIO
	// ---------------------------------------------------------------
	// Open drain only works if software left both pins as inputs. // RULE6
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pins_out <= '0;
		end else if (!ctl1_r[C1_EN]) begin
			pins_out <= gpio_out; // RULE5
		end else begin
			pins_out.scl_o <= 1'b0; // RULE4
			pins_out.sda_o <= 1'b0;
			if (is_master) begin
				pins_out.scl_oe <= !m_scl_r;
				pins_out.sda_oe <= !m_sda_r;
			end else if (is_slave) begin
				pins_out.scl_oe <= !ctl1_r[C1_CKP]; // RULE7
				pins_out.sda_oe <= !s_sda_r;
			end else begin
				// Firmware master and non two-wire codes drive nothing
				pins_out.scl_oe <= 1'b0; // RULE11 RULE12
				pins_out.sda_oe <= 1'b0;
			end
		end
	end

endmodule // ipcr_port

/* verif/ipcr_port_properties.sv */
// Purpose: Port-level checks.
// Assumes: Shadows track software writes.
// Notes:   Hardware may clear the release bit, so only stretch is checked.
module ipcr_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Register bus
	input wire ipcr_pkg::ipcr_avs_req_t avs_req,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Interrupt and pins
	input wire logic irq,
	input wire ipcr_pkg::ipcr_pin_out_t gpio_out,
	input wire ipcr_pkg::ipcr_pin_out_t pins_out,
	input wire logic port_active
);
	import ipcr_pkg::*;
	logic [7:0] ctl_r; // Last primary control written
	logic [7:0] msk_r; // Last mask written
	logic done; // Write completes at this edge
	logic str; // Slave with release bit low
	logic rel; // Mode that leaves both lines free
	assign done = avs_req.write && !avs_waitrequest && avs_req.byteenable[0];
	assign str = ctl_r[5] && ctl_r[2:1] == 2'h3 && !ctl_r[4];
	assign rel = ctl_r[5] && ctl_r[2:1] != 2'h3 && ctl_r[3:0] != MODE_MST;
	// Shadows follow completed writes only
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ctl_r <= 8'h00;
			msk_r <= 8'h00;
		end else if (done && avs_req.address == A_CTL1) begin
			ctl_r <= avs_req.writedata[7:0];
		end else if (done && avs_req.address == A_IMSK) begin
			msk_r <= avs_req.writedata[7:0];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	AST_WAIT_ON: assert property ((avs_req.read || avs_req.write)
		&& !$past(avs_req.read || avs_req.write) |-> avs_waitrequest) else $error("no wait");
	AST_ONE_WAIT: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("wait too long");
	AST_IDLE: assert property (!(avs_req.read || avs_req.write) |-> !avs_waitrequest)
		else $error("wait while idle");
	AST_UNMAP: assert property (avs_req.read && !avs_waitrequest && avs_req.address == 5'h1C
		|-> avs_readdata == 32'h0) else $error("unmapped read not zero");
	AST_MASK: assert property (msk_r[4:0] == 5'h00 |-> !irq) else $error("masked irq");
	AST_GPIO: assert property (!$past(port_active) && !$past(reset)
		|-> pins_out == $past(gpio_out)) else $error("gpio not passed");
	AST_OPEN: assert property (port_active && $past(port_active)
		|-> !pins_out.scl_o && !pins_out.sda_o) else $error("line driven high");
	AST_STRETCH: assert property (str && $past(str) |-> pins_out.scl_oe)
		else $error("clock not held");
	AST_NOMODE: assert property (rel && $past(rel)
		|-> !pins_out.scl_oe && !pins_out.sda_oe) else $error("line pulled");
endmodule // ipcr_chk
bind ipcr_port ipcr_chk u_ipcr_chk (.clock(clock), .reset(reset), .avs_req(avs_req),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
	.gpio_out(gpio_out), .pins_out(pins_out), .port_active(port_active));

/* verif/ipcr_peer.sv */
// Purpose: Pull-ups, a slave and an outside master.
// Assumes: Port drives open drain while enabled.
// Notes:   Peer acks only the first byte after each start and never stretches the clock.
module ipcr_peer (
	// Clock
	input wire logic clock,
	// Pins
	input wire ipcr_pkg::ipcr_pin_out_t pins_out,
	output ipcr_pkg::ipcr_pin_in_t pins_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import ipcr_pkg::*;
	logic scl; // Resolved clock line
	logic sda; // Resolved data line
	logic sda_low = 1'b0; // Peer pulls data low
	logic [7:0] tx = 8'hFF; // Byte shifted out
	logic [7:0] rx = 8'h00; // Byte shifted in
	int cnt = 0; // Clock falls since last start
	int starts = 0;
	int stops = 0;
	int seen = 0;
	// Pull-ups: a released line reads high
	assign scl = pins_out.scl_oe ? pins_out.scl_o : 1'b1;
	assign sda = (pins_out.sda_oe ? pins_out.sda_o : 1'b1) && !sda_low;
	assign pins_in = '{scl: scl, sda: sda};
	// Data edges with clock high are conditions
	always @(negedge sda) if (scl) starts++;
	always @(posedge sda) if (scl) stops++;
	// Sample data bits only, not the ack clock
	always @(posedge scl) if (cnt < 9) rx <= {rx[6:0], sda};
	// Next bit on each fall; ack low across the ninth clock
	always @(negedge scl) begin
		cnt = (starts != seen) ? 1 : cnt + 1;
		seen = starts;
		tx <= {tx[6:0], 1'b1};
		sda_low <= !tx[6] || cnt == 9;
	end
	// Present a byte for the port to clock in
	task automatic load(input logic [7:0] b);
		tx = b;
		sda_low = !b[7];
	endtask
	// Move data with clock high, as a master would
	task automatic cond(input logic low);
		repeat (4) @(posedge clock);
		sda_low <= low;
	endtask
endmodule // ipcr_peer

/* verif/tb.sv */
// Purpose: Self-checking bench for the port.
// Assumes: Peer acks only the first byte after a start; baud value 1 gives two clocks a quarter.
// Notes:   Requests go one at a time and only when the engine is idle.
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
	$display("CHECK FAILED at %0t: mismatch", $time); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ipcr_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	ipcr_avs_req_t avs_req = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic port_active;
	ipcr_pin_in_t pins_in;
	ipcr_pin_out_t gpio_out = '0; // Enables low keep the pins inputs
	ipcr_pin_out_t pins_out;
	int miscompares = 0;
	int check_count = 0;
	logic [7:0] q; // Last read byte
	always #2 clock = ~clock;
	ipcr_port u_ipcr_port (.clock(clock), .reset(reset), .avs_req(avs_req),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.pins_in(pins_in), .gpio_out(gpio_out), .pins_out(pins_out),
		.port_active(port_active));
	ipcr_peer u_ipcr_peer (.clock(clock), .pins_out(pins_out), .pins_in(pins_in));
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// One transfer, held until waitrequest is low
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		avs_req <= '{address: a, read: !w, write: w, writedata: {24'h0, d}, byteenable: 4'hF};
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest && n < 50);
		if (n >= 50) miscompares++;
		if (n >= 50) results();
		q = avs_readdata[7:0];
		avs_req <= '0;
		@(posedge clock);
	endtask
	// Read until the masked bits drop
	task automatic poll(input logic [4:0] a, input logic [7:0] m);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 8'h00);
			n++;
		end while ((q & m) !== 8'h00 && n < 200);
		`CHK(q & m, 8'h00)
		if (n >= 200) results();
	endtask
	task automatic t_reset();
		logic [4:0] regs [7] = '{A_CTL1, A_CTL2, A_BUF, A_BAUD, A_IST, A_IMSK, 5'h1C};
		bus(1'b1, 5'h1C, 8'hFF); // Unmapped write must vanish
		foreach (regs[i]) begin
			bus(1'b0, regs[i], 8'h00);
			`CHK(q, 8'h00)
		end
	endtask
	task automatic t_master();
		int s;
		bus(1'b1, A_BAUD, 8'h01);
		bus(1'b1, A_IMSK, 8'h01);
		bus(1'b1, A_CTL1, 8'h28);
		s = u_ipcr_peer.starts;
		bus(1'b1, A_CTL2, 8'h01);
		poll(A_CTL2, 8'h01);
		`CHK(u_ipcr_peer.starts, s + 1)
		`CHK(irq, 1'b1)
		bus(1'b1, A_IST, 8'h1F);
		`CHK(irq, 1'b0)
		bus(1'b1, A_BUF, 8'hA5);
		bus(1'b1, A_BUF, 8'h5A); // Engine busy: this write collides
		bus(1'b0, A_CTL1, 8'h00);
		`CHK(q[7], 1'b1)
		poll(A_BUS, 8'h04);
		`CHK(u_ipcr_peer.rx, 8'hA5)
		u_ipcr_peer.load(8'h3C);
		bus(1'b1, A_CTL2, 8'h08);
		poll(A_CTL2, 8'h08);
		u_ipcr_peer.load(8'hC3); // Buffer still unread: overflow
		bus(1'b1, A_CTL2, 8'h08);
		poll(A_CTL2, 8'h08);
		bus(1'b0, A_CTL1, 8'h00);
		`CHK(q[6], 1'b1)
		bus(1'b0, A_BUF, 8'h00);
		`CHK(q, 8'h3C)
		s = u_ipcr_peer.stops;
		bus(1'b1, A_CTL2, 8'h04);
		poll(A_CTL2, 8'h04);
		`CHK(u_ipcr_peer.stops, s + 1)
		s = u_ipcr_peer.starts;
		bus(1'b1, A_CTL2, 8'h00);
		repeat (20) @(posedge clock);
		`CHK(u_ipcr_peer.starts, s)
	endtask
	task automatic t_slave();
		logic [3:0] codes [4] = '{MODE_SLV10_SS, MODE_SLV7_SS, MODE_SLV10, MODE_SLV7};
		logic [7:0] ctl [4] = '{8'h2E, 8'h3E, 8'h3B, 8'h23};
		foreach (codes[i]) begin
			bus(1'b1, A_CTL1, {4'h3, codes[i]});
			bus(1'b1, A_IST, 8'h1F);
			u_ipcr_peer.cond(1'b1);
			u_ipcr_peer.cond(1'b0);
			repeat (4) @(posedge clock);
			bus(1'b0, A_IST, 8'h00);
			`CHK(q[2:1], codes[i][3] ? 2'h3 : 2'h0)
			`CHK(irq, 1'b0) // Start and stop bits are masked
		end
		foreach (ctl[i]) begin
			bus(1'b1, A_CTL1, ctl[i]);
			repeat (3) @(posedge clock);
			`CHK(pins_out, {1'b0, i == 0, 2'b00})
		end
	endtask
	task automatic t_gpio();
		bus(1'b1, A_CTL1, 8'h00);
		gpio_out <= 4'hA;
		repeat (3) @(posedge clock);
		`CHK(pins_out, 4'hA)
		`CHK(port_active, 1'b0)
	endtask
	initial begin
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		t_reset();
		t_master();
		t_slave();
		t_gpio();
		results();
	end
endmodule // tb
